// [inc/isasa_pkg.sv]
// constants, field positions and state codes for the two-wire port block
// assumes a 32-bit apb register bus and a 20 MHz system clock
package isasa_pkg;
	// ==================================================
	// register map (byte addresses)
	localparam int unsigned DW       = 32;
	localparam int unsigned AW       = 8;
	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_STAT = 8'h04;
	localparam logic [7:0]  OFS_ADDR = 8'h08;
	localparam logic [7:0]  OFS_MASK = 8'h0C;
	localparam logic [7:0]  OFS_RCV  = 8'h10;
	localparam logic [7:0]  OFS_TRN  = 8'h14;
	localparam logic [7:0]  OFS_RATE = 8'h18;
	localparam logic [7:0]  OFS_MCMD = 8'h1C;
	// ==================================================
	// serial_bus_control fields
	localparam int unsigned C_EN  = 15;
	localparam int unsigned C_SIDL = 13;
	localparam int unsigned C_REL = 12;
	localparam int unsigned C_ALL = 11;
	localparam int unsigned C_A10 = 10;
	localparam int unsigned C_SLW = 9;
	localparam int unsigned C_SMB = 8;
	localparam int unsigned C_GC  = 7;
	localparam int unsigned C_STR = 6;
	localparam logic [15:0] CTRL_RST   = 16'h1000;
	localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
	// ==================================================
	// status fields
	localparam int unsigned S_TBF = 0;
	localparam int unsigned S_RBF = 1;
	localparam int unsigned S_RW  = 2;
	localparam int unsigned S_STA = 3;
	localparam int unsigned S_STO = 4;
	localparam int unsigned S_DA  = 5;
	localparam int unsigned S_POV = 6;
	localparam int unsigned S_A10 = 8;
	localparam int unsigned S_GC  = 9;
	localparam int unsigned S_BCL = 10;
	localparam int unsigned MC_GO = 0;
	// ==================================================
	// address classes and bit counting
	localparam logic [4:0]  TEN_PREFIX = 5'h1E;
	localparam logic [6:0]  GC_ADDR    = 7'h00;
	localparam logic [6:0]  ORD_LO     = 7'h08;
	localparam logic [6:0]  ORD_HI     = 7'h77;
	localparam logic [3:0]  BIT_LAST   = 4'h7;
	localparam logic [3:0]  BIT_ACK    = 4'h8;
	localparam int unsigned RATE_W     = 16;
	localparam logic [9:0]  ADDR_RST   = 10'h000;
	localparam logic [15:0] RATE_RST   = 16'h0000;
	// ==================================================
	// state codes
	typedef enum logic [5:0] {
		SL_IDLE = 6'h01, SL_ADDR = 6'h02, SL_ADDR2 = 6'h04,
		SL_RX   = 6'h08, SL_TX   = 6'h10, SL_SKIP  = 6'h20
	} isasa_slave_e;
	typedef enum logic [2:0] {
		M_IDLE = 3'h1, M_LOW = 3'h2, M_HIGH = 3'h4
	} isasa_mst_e;
endpackage

// [logic/isasa_rate_ctr.sv]
// master rate down-counter with clock-arbitration wait
// assumes scl_high is already synchronised to clock
`timescale 1ns/1ps
module isasa_rate_ctr (
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic                          ce,
	// control
	input  wire logic                          load,
	input  wire logic                          arb,
	input  wire logic                          scl_high,
	input  wire logic [isasa_pkg::RATE_W-1:0]  reload,
	// status
	output logic                               expired
);
	import isasa_pkg::*;

	logic [RATE_W-1:0] cnt_reg;
	logic              wait_reg;

	// ==================================================
	// counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg  <= '0;
			wait_reg <= 1'b0;
		end else if (ce) begin
			if (load && arb) begin
				wait_reg <= 1'b1;
			end else if (wait_reg) begin
				// pause while another party holds the clock low
				if (scl_high) begin
					wait_reg <= 1'b0;
					cnt_reg  <= reload;
				end
			end else if (load) begin
				cnt_reg <= reload;
			end else if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

	assign expired = !wait_reg && (cnt_reg == '0);
endmodule

// [logic/isasa_top.sv]
// two-wire bus port: slave addressing, clock stretching, master arbitration
// assumes an apb master on clock and open-drain pins resolved outside
//
// Notes on behaviour
// - seven-bit mode compares low seven address bits
// - ten-bit first byte matches 11110 plus A9 A8
// - second byte compared only after first matches
// - classify general call, ordinary, ten-bit, reserved addresses
// - mask bits make address positions don't-care
// - accept-all acknowledges every address
// - general call only when enabled or accept-all set; raises slave event
// - transmit stretch after ninth clock if buffer empty
// - transmit after an address match always stretches; software must release
// - receive stretch per byte when stretch enabled
// - stretch enabled: software writes release freely
// - stretch disabled: only writes of one count
// - hardware clears release at transmit start, receive end
// - rate counter waits for clock high, then reloads
// - released data read low while clock high: collision
// - collision raises master event, master goes idle
// - data line changes only while clock low, except the master's release at the end of its byte
// - module enable hands pins to the block
// - halt-in-idle stops the engine during system idle
// - rate counter counts to zero then stops
// - complete byte moves to receive buffer, event pulse
// - collision flag sticky until software clears
`timescale 1ns/1ps
module isasa_top (
	// clock, reset, enables
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      sys_idle,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [isasa_pkg::AW-1:0]  paddr,
	input  wire logic [isasa_pkg::DW-1:0]  pwdata,
	output logic      [isasa_pkg::DW-1:0]  prdata,
	output logic                           pready,
	output logic                           pslverr,
	// bus pins
	input  wire logic                      scl_in,
	output logic                           scl_out,
	output logic                           scl_oe_n,
	input  wire logic                      sda_in,
	output logic                           sda_out,
	output logic                           sda_oe_n,
	// pin configuration and events
	output logic                           pins_owned,
	output logic                           slew_limit_disable,
	output logic                           smbus_input_levels,
	output logic                           slave_events_flag,
	output logic                           master_events_flag
);
	import isasa_pkg::*;

	function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] m);
		masked_eq = ((a ^ b) & ~m) == '0;
	endfunction

	logic [15:0]       serial_bus_control;
	logic [9:0]        slave_address_reg;
	logic [9:0]        address_mask_reg;
	logic [7:0]        receive_buffer_reg;
	logic [7:0]        transmit_holding_reg;
	logic [RATE_W-1:0] rate_reload_reg;
	logic              transmit_buffer_full, rbf_reg, pov_reg, bcl_reg;
	logic              gc_reg, a10_reg, da_reg, rw_reg, sta_reg, sto_reg;
	logic [1:0]        scl_sy, sda_sy;
	logic              scl_d, sda_d;
	isasa_slave_e      sl_state, sl_next;
	isasa_mst_e        m_state;
	logic [3:0]        bit_cnt, m_cnt;
	logic [7:0]        receive_shift_reg, sh_out, m_sh;
	logic              sl_sda_low, ten_matched, tx_pend, m_nack;
	logic              m_scl_low, m_sda_low, pready_reg, pslverr_reg;
	logic [DW-1:0]     prdata_reg, rd_mux;
	logic [15:0]       stat_v;
	logic              a_ack, rate_exp;
	isasa_slave_e      a_next;

	// ==================================================
	// pin synchronisers and line events
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_sy <= '1;
			sda_sy <= '1;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else if (ce) begin
			scl_sy <= {scl_sy[0], scl_in};
			sda_sy <= {sda_sy[0], sda_in};
			scl_d  <= scl_sy[1];
			sda_d  <= sda_sy[1];
		end
	end

	wire scl_s    = scl_sy[1];
	wire sda_s    = sda_sy[1];
	wire scl_rise = scl_s && !scl_d;
	wire scl_fall = !scl_s && scl_d;
	wire start_c  = scl_s && scl_d && sda_d && !sda_s;
	wire stop_c   = scl_s && scl_d && !sda_d && sda_s;
	wire run      = ce && !(serial_bus_control[C_SIDL] && sys_idle);
	wire eng      = run && serial_bus_control[C_EN];

	// ==================================================
	// address decision at the end of a byte
	always_comb begin
		a_ack  = 1'b0;
		a_next = SL_SKIP;
		if (sl_state == SL_ADDR) begin
			if (serial_bus_control[C_ALL]) begin
				a_ack  = 1'b1;
				a_next = receive_shift_reg[0] ? SL_TX : SL_RX;
			end else if (receive_shift_reg == {GC_ADDR, 1'b0}) begin
				a_ack  = serial_bus_control[C_GC];
				a_next = serial_bus_control[C_GC] ? SL_RX : SL_SKIP;
			end else if (serial_bus_control[C_A10]) begin
				if (masked_eq({1'b0, receive_shift_reg[7:1]},
					{1'b0, TEN_PREFIX, slave_address_reg[9:8]},
					{6'h00, address_mask_reg[9:8]})) begin
					// a read prefix is only ours after a full ten-bit write match
					a_ack  = !receive_shift_reg[0] || ten_matched;
					a_next = receive_shift_reg[0] ? (ten_matched ? SL_TX : SL_SKIP) : SL_ADDR2;
				end
			end else if (receive_shift_reg[7:1] >= ORD_LO && receive_shift_reg[7:1] <= ORD_HI
				&& masked_eq({1'b0, receive_shift_reg[7:1]}, {1'b0, slave_address_reg[6:0]},
				{1'b0, address_mask_reg[6:0]})) begin
				a_ack  = 1'b1;
				a_next = receive_shift_reg[0] ? SL_TX : SL_RX;
			end
		end else if (sl_state == SL_ADDR2) begin
			if (masked_eq(receive_shift_reg, slave_address_reg[7:0],
				address_mask_reg[7:0])) begin
				a_ack  = 1'b1;
				a_next = SL_RX;
			end
		end else if (sl_state == SL_RX) begin
			a_ack  = 1'b1;
			a_next = SL_RX;
		end else if (sl_state == SL_TX) begin
			a_next = SL_TX;
		end
	end

	wire tx_take  = eng && !start_c && !stop_c && tx_pend && serial_bus_control[C_REL];
	wire sl_edge  = eng && !start_c && !stop_c && !tx_take && sl_state != SL_IDLE && scl_fall;
	wire byte_end = sl_edge && bit_cnt == BIT_LAST;
	wire ack_end  = sl_edge && bit_cnt == BIT_ACK;
	wire store    = byte_end && a_ack && sl_state != SL_TX;
	wire tx_nack  = sl_state == SL_TX && m_nack;
	wire rel_clr  = ack_end && ((sl_next == SL_TX && !tx_nack
		&& (sl_state != SL_TX || !transmit_buffer_full))
		|| (sl_next == SL_RX && sl_state == SL_RX && serial_bus_control[C_STR]));
	wire sl_hold  = !serial_bus_control[C_REL] && (sl_state == SL_RX || sl_state == SL_TX)
		&& !scl_s;

	// ==================================================
	// slave engine
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sl_state <= SL_IDLE;
			sl_next <= SL_IDLE;
			bit_cnt <= '0;
			receive_shift_reg <= '0;
			sh_out <= '0;
			sl_sda_low <= 1'b0;
			ten_matched <= 1'b0;
			tx_pend <= 1'b0;
			m_nack <= 1'b0;
		end else if (run) begin
			if (!serial_bus_control[C_EN] || stop_c) begin
				sl_state <= SL_IDLE;
				sl_sda_low <= 1'b0;
				ten_matched <= 1'b0;
				tx_pend <= 1'b0;
			end else if (start_c) begin
				sl_state <= SL_ADDR;
				// the start's own clock fall wraps this to zero
				bit_cnt <= '1;
				sl_sda_low <= 1'b0;
				tx_pend <= 1'b0;
			end else if (tx_take) begin
				// clock is held low here, so the first bit is safe to place
				sh_out <= transmit_holding_reg;
				sl_sda_low <= !transmit_holding_reg[7];
				tx_pend <= 1'b0;
			end else if (scl_rise && sl_state != SL_IDLE) begin
				if (bit_cnt != BIT_ACK) begin
					receive_shift_reg <= {receive_shift_reg[6:0], sda_s};
				end else begin
					m_nack <= sda_s;
				end
			end else if (byte_end) begin
				bit_cnt <= BIT_ACK;
				sl_sda_low <= a_ack;
				sl_next <= a_next;
				if (sl_state == SL_ADDR2 && a_ack) begin
					ten_matched <= 1'b1;
				end
			end else if (ack_end) begin
				bit_cnt <= '0;
				sl_sda_low <= 1'b0;
				sl_state <= tx_nack ? SL_SKIP : sl_next;
				tx_pend <= sl_next == SL_TX && !tx_nack;
			end else if (sl_edge) begin
				bit_cnt <= bit_cnt + 1'b1;
				if (sl_state == SL_TX) begin
					sh_out <= {sh_out[6:0], 1'b1};
					sl_sda_low <= !sh_out[6];
				end
			end
		end
	end

	// ==================================================
	// master byte transmit with arbitration
	wire m_coll = m_state == M_HIGH && scl_s && !m_sda_low && !sda_s;
	wire m_go   = eng && m_state == M_IDLE && transmit_buffer_full
		&& pready_reg && psel && penable && pwrite && paddr == OFS_MCMD && pwdata[MC_GO];
	wire m_done = m_state == M_HIGH && !m_coll && rate_exp && m_cnt == BIT_LAST;
	wire r_load = eng && (m_go || (m_state == M_LOW && rate_exp)
		|| (m_state == M_HIGH && !m_coll && rate_exp && m_cnt != BIT_LAST));

	isasa_rate_ctr u_rate (
		.clock    (clock),
		.rst      (rst),
		.ce       (eng),
		.load     (r_load),
		.arb      (m_state == M_LOW),
		.scl_high (scl_s),
		.reload   (rate_reload_reg),
		.expired  (rate_exp)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			m_state <= M_IDLE;
			m_cnt <= '0;
			m_sh <= '0;
			m_scl_low <= 1'b0;
			m_sda_low <= 1'b0;
		end else if (run && !serial_bus_control[C_EN]) begin
			m_state <= M_IDLE;
			m_scl_low <= 1'b0;
			m_sda_low <= 1'b0;
		end else if (eng) begin
			unique case (m_state)
				M_IDLE: begin
					if (m_go) begin
						m_state <= M_LOW;
						m_sh <= transmit_holding_reg;
						m_cnt <= '0;
						m_scl_low <= 1'b1;
					end
				end
				M_LOW: begin
					// data moves one cycle after the clock went low
					m_sda_low <= !m_sh[7];
					if (rate_exp) begin
						m_scl_low <= 1'b0;
						m_state <= M_HIGH;
					end
				end
				M_HIGH: begin
					if (m_coll || m_done) begin
						m_state <= M_IDLE;
						m_scl_low <= 1'b0;
						m_sda_low <= 1'b0;
					end else if (rate_exp) begin
						m_state <= M_LOW;
						m_scl_low <= 1'b1;
						m_cnt <= m_cnt + 1'b1;
						m_sh <= {m_sh[6:0], 1'b1};
					end
				end
			endcase
		end
	end

	// ==================================================
	// apb slave: one wait state, registered answer
	wire acc   = psel && penable;
	wire wr_go = acc && pready_reg && pwrite;
	wire rd_go = acc && pready_reg && !pwrite;
	wire known = paddr == OFS_CTRL || paddr == OFS_STAT || paddr == OFS_ADDR
		|| paddr == OFS_MASK || paddr == OFS_RCV || paddr == OFS_TRN
		|| paddr == OFS_RATE || paddr == OFS_MCMD;

	always_comb begin
		stat_v = '0;
		stat_v[S_TBF] = transmit_buffer_full;
		stat_v[S_RBF] = rbf_reg;
		stat_v[S_RW] = rw_reg;
		stat_v[S_STA] = sta_reg;
		stat_v[S_STO] = sto_reg;
		stat_v[S_DA] = da_reg;
		stat_v[S_POV] = pov_reg;
		stat_v[S_A10] = a10_reg;
		stat_v[S_GC] = gc_reg;
		stat_v[S_BCL] = bcl_reg;
		unique case (paddr)
			OFS_CTRL: rd_mux = DW'(serial_bus_control);
			OFS_STAT: rd_mux = DW'(stat_v);
			OFS_ADDR: rd_mux = DW'(slave_address_reg);
			OFS_MASK: rd_mux = DW'(address_mask_reg);
			OFS_RCV:  rd_mux = DW'(receive_buffer_reg);
			OFS_TRN:  rd_mux = DW'(transmit_holding_reg);
			OFS_RATE: rd_mux = DW'(rate_reload_reg);
			OFS_MCMD: rd_mux = DW'(m_state != M_IDLE);
			default:  rd_mux = '0;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (ce) begin
			pready_reg <= acc && !pready_reg;
			pslverr_reg <= acc && !pready_reg && !known;
			if (acc && !pready_reg) begin
				prdata_reg <= pwrite ? '0 : rd_mux;
			end
		end
	end

	// ==================================================
	// control and configuration registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			serial_bus_control <= CTRL_RST;
			slave_address_reg <= ADDR_RST;
			address_mask_reg <= ADDR_RST;
			rate_reload_reg <= RATE_RST;
		end else if (ce) begin
			if (wr_go && paddr == OFS_CTRL) begin
				serial_bus_control <= pwdata[15:0] & CTRL_WMASK;
				serial_bus_control[C_REL] <= serial_bus_control[C_REL];
				// with stretching off, a zero write leaves the release alone
				if (serial_bus_control[C_STR] || pwdata[C_REL]) begin
					serial_bus_control[C_REL] <= pwdata[C_REL];
				end else if (rel_clr) begin
					serial_bus_control[C_REL] <= 1'b0;
				end
			end else if (rel_clr) begin
				serial_bus_control[C_REL] <= 1'b0;
			end
			if (wr_go && paddr == OFS_ADDR) begin
				slave_address_reg <= pwdata[9:0];
			end
			if (wr_go && paddr == OFS_MASK) begin
				address_mask_reg <= pwdata[9:0];
			end
			if (wr_go && paddr == OFS_RATE) begin
				rate_reload_reg <= pwdata[RATE_W-1:0];
			end
		end
	end

	// ==================================================
	// data buffers and status flags
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			transmit_holding_reg <= '0;
			transmit_buffer_full <= 1'b0;
		end else if (ce) begin
			if (wr_go && paddr == OFS_TRN) begin
				transmit_holding_reg <= pwdata[7:0];
				transmit_buffer_full <= 1'b1;
			end else if (tx_take || m_go) begin
				transmit_buffer_full <= 1'b0;
			end
		end
	end

	wire rcv_rd = rd_go && paddr == OFS_RCV;
	wire stat_w = wr_go && paddr == OFS_STAT;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			receive_buffer_reg <= '0;
			{rbf_reg, pov_reg, bcl_reg, gc_reg, a10_reg} <= '0;
			{da_reg, rw_reg, sta_reg, sto_reg} <= '0;
		end else if (ce) begin
			// an overflowing byte is dropped; the buffer keeps the unread one
			if (store && !(rbf_reg && !rcv_rd)) begin
				receive_buffer_reg <= receive_shift_reg;
			end
			rbf_reg <= store || (rbf_reg && !rcv_rd);
			pov_reg <= (store && rbf_reg && !rcv_rd) || (pov_reg && !(stat_w && !pwdata[S_POV]));
			bcl_reg <= (eng && m_coll) || (bcl_reg && !(stat_w && !pwdata[S_BCL]));
			if (eng && stop_c) begin
				{gc_reg, a10_reg, sto_reg, sta_reg} <= 4'h2;
			end else if (eng && start_c) begin
				{sto_reg, sta_reg} <= 2'h1;
			end else if (store && sl_state == SL_ADDR) begin
				gc_reg <= receive_shift_reg == {GC_ADDR, 1'b0};
				rw_reg <= receive_shift_reg[0];
				da_reg <= 1'b0;
			end else if (store) begin
				a10_reg <= a10_reg || sl_state == SL_ADDR2;
				da_reg <= sl_state == SL_RX;
			end
		end
	end

	// ==================================================
	// pins and output flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			pins_owned <= 1'b0;
			slew_limit_disable <= 1'b0;
			smbus_input_levels <= 1'b0;
			slave_events_flag <= 1'b0;
			master_events_flag <= 1'b0;
		end else if (ce) begin
			scl_oe_n <= !(serial_bus_control[C_EN] && (m_scl_low || sl_hold));
			sda_oe_n <= !(serial_bus_control[C_EN] && (m_sda_low || sl_sda_low));
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			pins_owned <= serial_bus_control[C_EN];
			slew_limit_disable <= serial_bus_control[C_SLW];
			smbus_input_levels <= serial_bus_control[C_SMB];
			slave_events_flag <= store;
			master_events_flag <= eng && (m_coll || m_done);
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
endmodule

// [verif/isasa_bus_model.sv]
// far-side bus master model: start, byte with ack, stop, data jam
// assumes pulled-up open-drain lines resolved in the bench
`timescale 1ns/1ps
module isasa_bus_model (
	// system clock and resolved lines
	input wire logic  clock,
	input wire logic  scl,
	input wire logic  sda,
	// pulls, low drives the line
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	// bits read back from the line, msb first
	logic [7:0] got;
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// released clock may be stretched by the slave
	task automatic wait_high();
		int n;
		n = 0;
		while (scl !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
	endtask
	// ==================================================
	// 5 cycles low, 3 high: 400 ns a bit
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_oe_n <= b;
		tick(4);
		scl_oe_n <= 1'b1;
		wait_high();
		tick(1);
		r = sda;
		tick(1);
		scl_oe_n <= 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
			got = {got[6:0], r};
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic start();
		sda_oe_n <= 1'b0;
		tick(4);
		scl_oe_n <= 1'b0;
	endtask
	task automatic stop();
		tick(1);
		sda_oe_n <= 1'b0;
		tick(4);
		scl_oe_n <= 1'b1;
		wait_high();
		tick(3);
		sda_oe_n <= 1'b1;
		tick(8);
	endtask
	task automatic jam(input logic on);
		sda_oe_n <= !on;
	endtask
endmodule

// [verif/isasa_chk.sv]
// checker for apb timing, event pulses and pin ownership
// assumes it is bound to isasa_top with one clock domain
`timescale 1ns/1ps
module isasa_chk (
	// clock and apb
	input wire logic                      clock,
	input wire logic                      rst,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [isasa_pkg::AW-1:0]  paddr,
	input wire logic [isasa_pkg::DW-1:0]  pwdata,
	input wire logic [isasa_pkg::DW-1:0]  prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	// pins and events
	input wire logic                      scl_in,
	input wire logic                      scl_oe_n,
	input wire logic                      sda_oe_n,
	input wire logic                      pins_owned,
	input wire logic                      slave_events_flag,
	input wire logic                      master_events_flag
);
	import isasa_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ==================================================
	// register bus
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (pready && paddr > OFS_MCMD |-> pslverr)
		else $error("unmapped access without error");
	err_data_zero_a: assert property (pready && pslverr |-> prdata == '0)
		else $error("refused read returned data");
	// ==================================================
	// events and pins
	slave_pulse_a: assert property (slave_events_flag |=> !slave_events_flag)
		else $error("slave event not a pulse");
	master_pulse_a: assert property (master_events_flag |=> !master_events_flag)
		else $error("master event not a pulse");
	enable_copy_a: assert property (pready && psel && pwrite && paddr == OFS_CTRL
		|-> ##2 pins_owned == $past(pwdata[C_EN], 2)) else $error("pin ownership lags");
	pins_idle_a: assert property (!pins_owned && $past(!pins_owned)
		|-> scl_oe_n && sda_oe_n) else $error("pins driven while disabled");
	sda_drive_low_a: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("data pulled while clock high");
	cover property (slave_events_flag);
	cover property (master_events_flag);
	cover property (pready && pslverr);
endmodule
bind isasa_top isasa_chk isasa_chk_inst (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
	.sda_oe_n(sda_oe_n), .pins_owned(pins_owned), .slave_events_flag(slave_events_flag),
	.master_events_flag(master_events_flag));

// [verif/isasa_top_test.sv]
// self-checking bench for the two-wire port block
// assumes the bus model stands on the far side of the pins
`timescale 1ns/1ps
module isasa_top_test;
	import isasa_pkg::*;
	logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sys_idle = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, seed = 32'd12977;
	logic err, ack;
	wire [31:0] prdata;
	wire pready, pslverr, scl_d, sda_d, scl_m, sda_m, sev_p, mev_p;
	wire scl = scl_d & scl_m;
	wire sda = sda_d & sda_m;
	int n_mismatch = 0, num_checks = 0, sev = 0, mev = 0, e, n;
	int cfg[13][5] = '{'{'h9000, 'h55, 0, 'hAA, 0}, '{'h9000, 'h55, 0, 'hA8, 0},
		'{'h9000, 'h55, 1, 'hA8, 0}, '{'h9800, 'h55, 0, 'h26, 0}, '{'h9000, 'h55, 0, 0, 0},
		'{'h9080, 'h55, 0, 0, 0}, '{'h9000, 'h02, 0, 'h04, 0}, '{'h9400, 'h2A5, 0, 'hF4, 'hA5},
		'{'h9400, 'h2A5, 0, 'hF4, 'hA4}, '{'h9400, 'h2A5, 0, 'hF2, 'hA5},
		'{'h9400, 'h2A5, 1, 'hF4, 'hA4}, '{'hB000, 'h55, 0, 'hAA, 0},
		'{'h9000, 'h55, 'h40, 'h2A, 0}};
	always #25 clock = ~clock;
	always @(posedge clock) begin
		sev <= sev + (sev_p === 1'b1);
		mev <= mev + (mev_p === 1'b1);
	end
	isasa_top isasa_top_inst (.clock(clock), .rst(rst), .ce(1'b1), .sys_idle(sys_idle),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(),
		.scl_oe_n(scl_d), .sda_in(sda), .sda_out(), .sda_oe_n(sda_d), .pins_owned(),
		.slew_limit_disable(), .smbus_input_levels(), .slave_events_flag(sev_p),
		.master_events_flag(mev_p));
	isasa_bus_model far (.clock(clock), .scl(scl), .sda(sda), .scl_oe_n(scl_m),
		.sda_oe_n(sda_m));
	// ==================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected acknowledge of the first address byte
	function automatic logic exp_ack(int c, int sa, int mk, int b);
		int a = b >> 1;
		if (c[C_SIDL]) return 1'b0;
		if (c[C_ALL]) return 1'b1;
		if (c[C_A10]) return ((b ^ (8'hF0 | sa >> 7)) & ~(mk >> 7) & 8'hFE) == 0;
		if (a == 0) return c[C_GC] && !b[0];
		return ((a ^ sa) & ~mk & 8'h7F) == 0 && a >= 8 && a <= 8'h77;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		end_of_test();
	end
	// ==================================================
	// scenarios
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		apb(0, OFS_CTRL, 0);
		chk(rd, CTRL_RST);
		apb(1, OFS_CTRL, 'hD040);
		apb(1, OFS_CTRL, 'h8040);
		apb(0, OFS_CTRL, 0);
		chk(rd, 'h8040);
		apb(1, OFS_CTRL, 'h9000);
		apb(1, OFS_CTRL, 'h8000);
		apb(0, OFS_CTRL, 0);
		chk(rd, 'h9000);
		apb(0, 8'h40, 0);
		chk(err, 1'b1);
		foreach (cfg[i]) begin
			sys_idle <= cfg[i][0][C_SIDL];
			apb(1, OFS_CTRL, cfg[i][0]);
			apb(1, OFS_ADDR, cfg[i][1]);
			apb(1, OFS_MASK, cfg[i][2]);
			apb(0, OFS_RCV, 0);
			e = sev;
			far.start();
			far.put_byte(cfg[i][3], ack);
			chk(ack, exp_ack(cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3]));
			if (cfg[i][0][C_A10] && ack) begin
				far.put_byte(cfg[i][4], ack);
				chk(ack, ((cfg[i][4] ^ cfg[i][1]) & ~cfg[i][2] & 'hFF) == 0);
			end
			far.stop();
			if (!cfg[i][0][C_A10])
				chk(sev != e, ack);
		end
		apb(1, OFS_CTRL, 'h9040);
		apb(0, OFS_RCV, 0);
		far.start();
		far.put_byte('hAA, ack);
		apb(0, OFS_RCV, 0);
		chk(rd, 'hAA);
		e = rnd() & 'hFF;
		far.put_byte(e, ack);
		chk(ack, 1'b1);
		// the hold lands a few cycles after the ninth fall
		repeat (4) @(posedge clock);
		apb(0, OFS_CTRL, 0);
		chk(rd, 'h8040);
		chk(scl_d, 1'b0);
		apb(0, OFS_RCV, 0);
		chk(rd, e);
		apb(1, OFS_CTRL, 'h9040);
		far.stop();
		apb(1, OFS_CTRL, 'h9000);
		far.start();
		far.put_byte('hAB, ack);
		repeat (4) @(posedge clock);
		apb(0, OFS_CTRL, 0);
		chk(rd, 'h8000);
		chk(scl_d, 1'b0);
		apb(1, OFS_TRN, e);
		apb(1, OFS_CTRL, 'h9000);
		far.put_byte('hFF, ack);
		chk(far.got, e);
		far.stop();
		apb(1, OFS_RATE, 4);
		apb(1, OFS_TRN, 'hFF);
		e = mev;
		apb(1, OFS_MCMD, 1);
		for (n = 0; n < 100 && scl_d !== 1'b0; n++) @(posedge clock);
		far.jam(1'b1);
		for (n = 0; n < 300 && mev == e; n++) @(posedge clock);
		chk(mev - e, 1);
		apb(0, OFS_STAT, 0);
		chk(rd[S_BCL], 1'b1);
		apb(0, OFS_MCMD, 0);
		chk(rd[MC_GO], 1'b0);
		far.jam(1'b0);
		apb(1, OFS_STAT, 0);
		apb(0, OFS_STAT, 0);
		chk(rd[S_BCL], 1'b0);
		end_of_test();
	end
endmodule
